/* File: src/nip_pkg.sv */
// Functional notes
// - Node valid flag clears on bus reset, sets when a new node number arrives.
// - Root flag is loaded during bus reset processing from the PHY root report.
// - Node identity reserved bits 29-28 and 26-16 always read zero.
// - Cable power ok flag follows the PHY cable power good report.
// - Bus segment bits 15-6 are software writable; reset all ones, upper zero.
// - Node number bits 5-0 load from PHY after self-ID; software cannot write.
// - The 16-bit node ID is bus segment above node number.
// - Read complete flag clears when software sets the read or write request.
// - Read complete flag sets whenever a register transfer arrives from PHY.
// - Each PHY register transfer captures address into 27-24, data into 23-16.
// - Read request bit 15 set by software, cleared once the request is sent.
// - Write request bit 14 set by software, cleared once the request is sent.
// - Target address from bits 11-8, write value from 7-0, unused on reads.
// - PHY port reserved bits 30-28 and 13-12 always read zero.
package nip_pkg;
	localparam int APB_AW = 12;
	typedef logic [APB_AW-1:0] nip_addr_t;
	// Register byte addresses.
	localparam nip_addr_t OFF_NODE_ID = 12'h0e8;
	localparam nip_addr_t OFF_PHY_PORT = 12'h0ec;
	localparam nip_addr_t OFF_IRQ_STAT = 12'h0d8;
	localparam nip_addr_t OFF_IRQ_MASK = 12'h0dc;
	// Node identity layout.
	localparam int NID_VALID_BIT = 31;
	localparam int NID_ROOT_BIT = 30;
	localparam int NID_CPS_BIT = 27;
	localparam int NID_SEG_LSB = 6;
	localparam int NID_SEG_W = 10;
	localparam int NID_NUM_W = 6;
	localparam logic [NID_SEG_W-1:0] NID_SEG_RST = 10'h3ff;
	localparam logic [NID_NUM_W-1:0] NID_NUM_RST = 6'h3f;
	// PHY register port layout.
	localparam int PRT_DONE_BIT = 31;
	localparam int PRT_RADDR_LSB = 24;
	localparam int PRT_RDATA_LSB = 16;
	localparam int PRT_RD_BIT = 15;
	localparam int PRT_WR_BIT = 14;
	localparam int PRT_TADDR_LSB = 8;
	localparam int PRT_WDATA_LSB = 0;
	localparam int PHY_AW = 4;
	localparam int PHY_DW = 8;
	localparam logic [PHY_AW-1:0] PRT_ADDR_RST = 4'h0;
	localparam logic [PHY_DW-1:0] PRT_DATA_RST = 8'h00;
	// Interrupt event bits.
	localparam int IRQ_W = 4;
	localparam int EVT_BUS_RESET = 0;
	localparam int EVT_NODE_VALID = 1;
	localparam int EVT_PHY_RETURN = 2;
	localparam int EVT_REQ_SENT = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
	// Request sequencer states, Gray ordered.
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01
	} nip_state_e;
	// Request toward the PHY.
	typedef struct packed {
		logic write;
		logic [PHY_AW-1:0] addr;
		logic [PHY_DW-1:0] data;
	} nip_phy_req_s;
	// Register transfer coming back from the PHY.
	typedef struct packed {
		logic [PHY_AW-1:0] addr;
		logic [PHY_DW-1:0] data;
	} nip_phy_ret_s;
endpackage

/* File: src/nip_irq_ctrl.sv */
`timescale 1ns/100ps
module nip_irq_ctrl
	import nip_pkg::*;
#(
	parameter int W = IRQ_W
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Event pulses.
	input wire logic [W-1:0] evt,
	// Software access.
	input wire logic statClrEn,
	input wire logic maskWrEn,
	input wire logic [W-1:0] phy_write_value,
	// State.
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	logic [W-1:0] status_r;
	logic [W-1:0] mask_r;
	logic irq_r;
	logic [W-1:0] status_nxt;
	logic [W-1:0] mask_nxt;

	// Write one clears; an event in the same cycle wins over its clear.
	assign status_nxt = (status_r & ~(statClrEn ? phy_write_value : '0)) | evt;
	assign mask_nxt = maskWrEn ? phy_write_value : mask_r;

	// Sticky status, mask and the registered level interrupt.
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_r <= IRQ_RST;
			mask_r <= IRQ_RST;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= |(status_nxt & mask_nxt);
		end
	end

	assign status = status_r;
	assign mask = mask_r;
	assign irq = irq_r;
endmodule

/* File: src/nip_phy_reg_access.sv */
`timescale 1ns/100ps
module nip_phy_reg_access
	import nip_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire nip_addr_t paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Node status from the PHY.
	input wire logic busResetDetected,
	input wire logic selfIdDone,
	input wire logic [NID_NUM_W-1:0] selfIdNodeNum,
	input wire logic phyIsRoot,
	input wire logic cablePowerOk,
	// Register request toward the PHY.
	output logic phyReqValid,
	output nip_phy_req_s phyReq,
	input wire logic phyReqReady,
	// Register transfer from the PHY.
	input wire logic phyRetValid,
	input wire nip_phy_ret_s phyRet,
	// Node identity and interrupt.
	output logic [15:0] nodeId,
	output logic nodeIdValid,
	output logic irq
);
	// Address match helper shared by every decode.
	function automatic logic regHit(input nip_addr_t a, input nip_addr_t off);
		regHit = (a[APB_AW-1:2] == off[APB_AW-1:2]);
	endfunction

	// APB state.
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	// Node identity state.
	logic nodeValid_r;
	logic root_r;
	logic cps_r;
	logic [NID_SEG_W-1:0] segment_r;
	logic [NID_SEG_W-1:0] segment_nxt;
	logic [NID_NUM_W-1:0] nodeNum_r;
	logic [NID_NUM_W-1:0] nodeNum_nxt;
	logic nodeValid_nxt;
	// PHY port state.
	logic readDone_r;
	logic readDone_nxt;
	logic [PHY_AW-1:0] retAddr_r;
	logic [PHY_DW-1:0] retData_r;
	logic pendRd_r;
	logic pendRd_nxt;
	logic pendWr_r;
	logic pendWr_nxt;
	logic [PHY_AW-1:0] tgtAddr_r;
	logic [PHY_DW-1:0] wrValue_r;
	nip_state_e state_r;
	nip_state_e state_nxt;
	logic reqValid_r;
	nip_phy_req_s req_r;
	nip_phy_req_s req_nxt;

	// Bus phase decode.
	wire accessFirst = psel && penable && !pready_r;
	wire apbDone = psel && penable && pready_r;
	wire apbWr = apbDone && pwrite;
	wire hitNode = regHit(paddr, OFF_NODE_ID);
	wire hitPort = regHit(paddr, OFF_PHY_PORT);
	wire hitStat = regHit(paddr, OFF_IRQ_STAT);
	wire hitMask = regHit(paddr, OFF_IRQ_MASK);
	wire hitAny = hitNode || hitPort || hitStat || hitMask;
	wire wrNode = apbWr && hitNode;
	wire wrPort = apbWr && hitPort;

	// Interrupt block wiring.
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqMask;
	logic [IRQ_W-1:0] irqEvt;
	wire reqSent = reqValid_r && phyReqReady;

	// Events feeding the sticky status bits.
	assign irqEvt[EVT_BUS_RESET] = busResetDetected;
	assign irqEvt[EVT_NODE_VALID] = selfIdDone;
	assign irqEvt[EVT_PHY_RETURN] = phyRetValid;
	assign irqEvt[EVT_REQ_SENT] = reqSent;

	nip_irq_ctrl #(
		.W(IRQ_W)
	) u_irq (
		.mclk(mclk),
		.rst(rst),
		.evt(irqEvt),
		.statClrEn(apbWr && hitStat),
		.maskWrEn(apbWr && hitMask),
		.phy_write_value(pwdata[IRQ_W-1:0]),
		.status(irqStatus),
		.mask(irqMask),
		.irq(irq)
	);

	// Read words; reserved bits are tied to zero.
	wire [31:0] nodeWord = {nodeValid_r, root_r, 2'b00, cps_r, 11'h000,
		segment_r, nodeNum_r};
	wire [31:0] portWord = {readDone_r, 3'b000, retAddr_r, retData_r,
		pendRd_r, pendWr_r, 2'b00, tgtAddr_r, wrValue_r};
	wire [31:0] readMux = hitNode ? nodeWord :
		hitPort ? portWord :
		hitStat ? {28'h0000000, irqStatus} :
		hitMask ? {28'h0000000, irqMask} : 32'h00000000;

	// APB answer: one wait state, data and error registered.
	always_ff @(posedge mclk) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= accessFirst;
			if (accessFirst) begin
				pslverr_r <= !hitAny;
				prdata_r <= pwrite ? 32'h00000000 : readMux;
			end
		end
	end

	// Node identity updates; a new node number beats a bus reset in the same cycle.
	assign nodeValid_nxt = selfIdDone ? 1'b1 : (busResetDetected ? 1'b0 : nodeValid_r);
	assign nodeNum_nxt = selfIdDone ? selfIdNodeNum : nodeNum_r;
	assign segment_nxt = wrNode ? pwdata[NID_SEG_LSB +: NID_SEG_W] : segment_r;

	// Node identity registers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			nodeValid_r <= 1'b0;
			root_r <= 1'b0;
			cps_r <= 1'b0;
			segment_r <= NID_SEG_RST;
			nodeNum_r <= NID_NUM_RST;
		end else begin
			nodeValid_r <= nodeValid_nxt;
			if (busResetDetected || selfIdDone) begin
				root_r <= phyIsRoot;
			end
			cps_r <= cablePowerOk;
			segment_r <= segment_nxt;
			nodeNum_r <= nodeNum_nxt;
		end
	end

	// The exported node ID is the segment above the node number.
	assign nodeId = {segment_r, nodeNum_r};
	assign nodeIdValid = nodeValid_r;

	// Software request decode; a new request is taken only when none is pending.
	wire portIdle = !pendRd_r && !pendWr_r;
	wire swRd = wrPort && portIdle && pwdata[PRT_RD_BIT];
	wire swWr = wrPort && portIdle && pwdata[PRT_WR_BIT] && !pwdata[PRT_RD_BIT];
	wire swReq = swRd || swWr;

	// Pending bits: set by software, dropped when the transfer is accepted.
	assign pendRd_nxt = swRd ? 1'b1 : ((reqSent && !req_r.write) ? 1'b0 : pendRd_r);
	assign pendWr_nxt = swWr ? 1'b1 : ((reqSent && req_r.write) ? 1'b0 : pendWr_r);
	// Completion flag: an arriving transfer wins over the software clear.
	assign readDone_nxt = phyRetValid ? 1'b1 : (swReq ? 1'b0 : readDone_r);

	// PHY port registers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			readDone_r <= 1'b0;
			retAddr_r <= PRT_ADDR_RST;
			retData_r <= PRT_DATA_RST;
			pendRd_r <= 1'b0;
			pendWr_r <= 1'b0;
			tgtAddr_r <= PRT_ADDR_RST;
			wrValue_r <= PRT_DATA_RST;
		end else begin
			readDone_r <= readDone_nxt;
			pendRd_r <= pendRd_nxt;
			pendWr_r <= pendWr_nxt;
			if (phyRetValid) begin
				retAddr_r <= phyRet.addr;
				retData_r <= phyRet.data;
			end
			if (wrPort) begin
				tgtAddr_r <= pwdata[PRT_TADDR_LSB +: PHY_AW];
				wrValue_r <= pwdata[PRT_WDATA_LSB +: PHY_DW];
			end
		end
	end

	// Sequencer: launch one transfer per pending bit and hold it until taken.
	always_comb begin
		state_nxt = state_r;
		req_nxt = req_r;
		unique case (state_r)
			ST_IDLE: begin
				if (!portIdle) begin
					state_nxt = ST_SEND;
					req_nxt.write = pendWr_r;
					req_nxt.addr = tgtAddr_r;
					req_nxt.data = pendWr_r ? wrValue_r : PRT_DATA_RST;
				end
			end
			ST_SEND: begin
				if (phyReqReady) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			reqValid_r <= 1'b0;
			req_r <= '0;
		end else begin
			state_r <= state_nxt;
			reqValid_r <= (state_nxt == ST_SEND);
			req_r <= req_nxt;
		end
	end

	assign phyReqValid = reqValid_r;
	assign phyReq = req_r;
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// Checks on the behaviour above.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence seqNodeRead;
		psel && penable && !pready && !pwrite && hitNode;
	endsequence
	sequence seqPortRead;
		psel && penable && !pready && !pwrite && hitPort;
	endsequence
	sequence seqRdIssue;
		psel && penable && pready && pwrite && hitPort && !pendRd_r && !pendWr_r
			&& pwdata[PRT_RD_BIT];
	endsequence
	sequence seqRdLaunch;
		phyReqValid && !phyReq.write ##0 pendRd_r;
	endsequence
	sequence seqWrIssue;
		psel && penable && pready && pwrite && hitPort && portIdle && pwdata[PRT_WR_BIT]
			&& !pwdata[PRT_RD_BIT];
	endsequence
	sequence seqWrLaunch;
		phyReqValid && phyReq.write ##0 pendWr_r;
	endsequence
	sequence seqReqTarget;
		phyReq.addr == $past(pwdata[PRT_TADDR_LSB +: PHY_AW], 2);
	endsequence
	sequence seqWrValue;
		phyReq.data == $past(pwdata[PRT_WDATA_LSB +: PHY_DW], 2);
	endsequence
	sequence seqRdValue;
		phyReq.data == PRT_DATA_RST;
	endsequence
	sequence seqPortFields;
		tgtAddr_r == $past(pwdata[PRT_TADDR_LSB +: PHY_AW])
			&& wrValue_r == $past(pwdata[PRT_WDATA_LSB +: PHY_DW]);
	endsequence
	sequence seqNodeWord;
		prdata[15:0] == $past(nodeId)
			&& prdata[NID_VALID_BIT] == $past(nodeIdValid);
	endsequence
	sequence seqPortPend;
		prdata[PRT_RD_BIT] == $past(pendRd_r)
			&& prdata[PRT_WR_BIT] == $past(pendWr_r);
	endsequence

	AST_VALID_CLR: assert property (busResetDetected && !selfIdDone |=> !nodeIdValid)
		else $error("valid flag not cleared by bus reset");
	AST_VALID_SET: assert property (selfIdDone |=> nodeIdValid
			&& nodeId[NID_NUM_W-1:0] == $past(selfIdNodeNum))
		else $error("node number not loaded after self-ID");
	AST_ROOT: assert property (busResetDetected |=> root_r == $past(phyIsRoot))
		else $error("root flag not taken during bus reset");
	AST_CPS: assert property (##1 cps_r == $past(cablePowerOk))
		else $error("cable power flag does not follow PHY");
	AST_NODE_RSVD: assert property (seqNodeRead |=> pready && prdata[29:28] == 2'b00
			&& prdata[26:16] == 11'h000)
		else $error("node identity reserved bits not zero");
	AST_PORT_RSVD: assert property (seqPortRead |=> pready && prdata[30:28] == 3'b000
			&& prdata[13:12] == 2'b00)
		else $error("port reserved bits not zero");
	AST_SEG_WRITE: assert property (wrNode |=> nodeId[15:6] == $past(pwdata[15:6]))
		else $error("bus segment write lost");
	AST_NUM_RO: assert property (wrNode && !selfIdDone |=> $stable(nodeId[5:0]))
		else $error("node number changed by software");
	AST_DONE_CLR: assert property (swReq && !phyRetValid |=> !readDone_r)
		else $error("read complete not cleared by request");
	AST_DONE_SET: assert property (phyRetValid |=> readDone_r
			&& retAddr_r == $past(phyRet.addr) && retData_r == $past(phyRet.data))
		else $error("PHY transfer not captured");
	AST_RD_LAUNCH: assert property (seqRdIssue |-> ##2 seqRdLaunch)
		else $error("read request not launched in two cycles");
	AST_SENT_CLR: assert property (phyReqValid && phyReqReady |=> portIdle && !phyReqValid)
		else $error("request bit not cleared after send");
	AST_REQ_HOLD: assert property (phyReqValid && !phyReqReady |=> phyReqValid
			&& $stable(phyReq))
		else $error("request dropped before acceptance");

	// Launch of requests and the fields that travel with them.
	AST_WR_LAUNCH: assert property (seqWrIssue |-> ##2 seqWrLaunch)
		else $error("write request not launched in two cycles");
	AST_WR_FIELDS: assert property (seqWrIssue |-> ##2 seqReqTarget ##0 seqWrValue)
		else $error("write request fields wrong");
	AST_RD_FIELDS: assert property (seqRdIssue |-> ##2 seqReqTarget ##0 seqRdValue)
		else $error("read request fields wrong");
	AST_RD_PENDING: assert property (seqRdIssue |=> pendRd_r && !pendWr_r)
		else $error("read request bit not set");
	AST_REQ_EXCL: assert property (!(pendRd_r && pendWr_r))
		else $error("read and write pending together");
	AST_PORT_FIELDS: assert property (wrPort |=> seqPortFields)
		else $error("target address or write value not stored");

	// Fields that only their own events may change.
	AST_VALID_HOLD: assert property (!busResetDetected && !selfIdDone
			|=> $stable(nodeIdValid))
		else $error("valid flag moved without an event");
	AST_ROOT_HOLD: assert property (!busResetDetected && !selfIdDone |=> $stable(root_r))
		else $error("root flag moved outside bus reset");
	AST_NUM_HOLD: assert property (!selfIdDone |=> $stable(nodeId[NID_NUM_W-1:0]))
		else $error("node number moved without self-ID");
	AST_SEG_HOLD: assert property (!wrNode |=> $stable(nodeId[15:6]))
		else $error("bus segment moved without a write");
	AST_RET_HOLD: assert property (!phyRetValid
			|=> $stable(retAddr_r) && $stable(retData_r))
		else $error("returned fields moved without a transfer");
	AST_DONE_HOLD: assert property (!phyRetValid && !swReq |=> $stable(readDone_r))
		else $error("read complete moved without a cause");

	// Read words carry the live register state.
	AST_NODE_WORD: assert property (seqNodeRead |=> seqNodeWord)
		else $error("node identity read does not match node ID");
	AST_PORT_PEND: assert property (seqPortRead |=> seqPortPend)
		else $error("request bits do not read back pending state");
endmodule

/* File: tb/nip_phy_model.sv */
`timescale 1ns/100ps
module nip_phy_model
	import nip_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Cycles to stall before taking a request.
	input wire logic [3:0] stall,
	// Requests from the link.
	input wire logic phyReqValid,
	input wire nip_phy_req_s phyReq,
	output logic phyReqReady,
	// Register transfers back to the link.
	output logic phyRetValid,
	output nip_phy_ret_s phyRet,
	output nip_phy_req_s lastReq
);
	logic [3:0] waitCnt;
	// Takes a request after the stall and answers a read one cycle later.
	always @(posedge mclk) begin
		if (rst) begin
			waitCnt <= 4'h0;
			phyReqReady <= 1'b0;
			phyRetValid <= 1'b0;
			phyRet <= '0;
			lastReq <= '0;
		end else begin
			waitCnt <= (phyReqValid && !phyReqReady) ? waitCnt + 4'h1 : 4'h0;
			phyReqReady <= phyReqValid && !phyReqReady && (waitCnt >= stall);
			phyRetValid <= phyReqValid && phyReqReady && !phyReq.write;
			if (phyReqValid && phyReqReady) begin
				lastReq <= phyReq;
				phyRet <= {phyReq.addr, phyReq.addr, ~phyReq.addr};
			end else begin
				phyRet <= ~phyRet; // Return lines toggle while idle.
			end
		end
	end
endmodule

/* File: tb/node_id_phy_reg_access_bench.sv */
`timescale 1ns/100ps
module node_id_phy_reg_access_bench
	import nip_pkg::*;
;
	logic mclk, rst, psel, penable, pwrite, busRst, idDone, isRoot, cpOk;
	logic pready, pslverr, reqValid, reqReady, retValid, nodeIdValid, irq, rErr;
	logic [31:0] pwdata, prdata, rData;
	logic [5:0] idNum;
	logic [15:0] nodeId;
	logic [3:0] stall;
	nip_addr_t paddr;
	nip_phy_req_s phyReq, lastReq;
	nip_phy_ret_s phyRet;
	int failCount = 0;
	int checks = 0;
	nip_phy_reg_access i_nip_phy_reg_access(.mclk(mclk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busResetDetected(busRst), .selfIdDone(idDone),
		.selfIdNodeNum(idNum), .phyIsRoot(isRoot), .cablePowerOk(cpOk), .phyReqValid(reqValid),
		.phyReq(phyReq), .phyReqReady(reqReady), .phyRetValid(retValid), .phyRet(phyRet),
		.nodeId(nodeId), .nodeIdValid(nodeIdValid), .irq(irq));
	nip_phy_model i_nip_phy_model(.mclk(mclk), .rst(rst), .stall(stall),
		.phyReqValid(reqValid), .phyReq(phyReq), .phyReqReady(reqReady),
		.phyRetValid(retValid), .phyRet(phyRet), .lastReq(lastReq));
	// Clock generator.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", checks, failCount);
		if (failCount == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; waits for pready under a bound.
	task automatic apb(input logic wr, input nip_addr_t a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			failCount++;
			giveVerdict();
		end
		rData = prdata;
		rErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Waits for a read answer (sel 0) or a request handshake (sel 1).
	task automatic waitPhy(input logic sel);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((sel ? (reqValid && reqReady) : retValid) !== 1'b1 && n < 50);
		if ((sel ? (reqValid && reqReady) : retValid) !== 1'b1) begin
			failCount++;
			giveVerdict();
		end
	endtask
	// Pulses a bus reset or a self-ID completion for one cycle.
	task automatic pulse(input logic sid);
		@(posedge mclk);
		busRst <= !sid;
		idDone <= sid;
		@(posedge mclk);
		busRst <= 1'b0;
		idDone <= 1'b0;
	endtask
	task automatic testReset;
		apb(1'b0, OFF_NODE_ID, '0);
		chk("node reset", rData, 32'h0000ffff);
		chk("node error", {31'h0, rErr}, 32'h0);
		chk("node number", {26'h0, nodeId[5:0]}, 32'h0000003f);
		apb(1'b0, OFF_PHY_PORT, '0);
		chk("port reset", rData, 32'h00000000);
		$display("testReset done");
	endtask
	task automatic testNode;
		isRoot <= 1'b1;
		cpOk <= 1'b1;
		pulse(1'b0);
		apb(1'b0, OFF_NODE_ID, '0);
		chk("node after reset", rData, 32'h4800ffff);
		idNum <= 6'h05;
		pulse(1'b1);
		apb(1'b1, OFF_NODE_ID, 32'hffff5540);
		apb(1'b0, OFF_NODE_ID, '0);
		chk("node written", rData, 32'hc8005545);
		chk("node id", {16'h0, nodeId}, 32'h00005545);
		chk("node valid set", {31'h0, nodeIdValid}, 32'h1);
		isRoot <= 1'b0;
		cpOk <= 1'b0;
		pulse(1'b0);
		apb(1'b0, OFF_NODE_ID, '0);
		chk("node second reset", rData, 32'h00005545);
		chk("node valid", {31'h0, nodeIdValid}, 32'h0);
		$display("testNode done");
	endtask
	task automatic testPhy;
		stall <= 4'h2;
		apb(1'b1, OFF_PHY_PORT, 32'h00008a77);
		waitPhy(1'b0);
		chk("read request", {19'h0, lastReq}, {19'h0, 1'b0, 4'ha, 8'h00});
		apb(1'b0, OFF_PHY_PORT, '0);
		chk("read result", rData, 32'h8aa50a77);
		stall <= 4'h8;
		apb(1'b1, OFF_PHY_PORT, 32'h00004c3c);
		apb(1'b0, OFF_PHY_PORT, '0);
		chk("write pending", rData & 32'hc000c000, 32'h00004000);
		waitPhy(1'b1);
		apb(1'b0, OFF_PHY_PORT, '0);
		chk("write sent", rData & 32'h0000ffff, 32'h00000c3c);
		chk("write request", {19'h0, lastReq}, {19'h0, 1'b1, 4'hc, 8'h3c});
		$display("testPhy done");
	endtask
	task automatic testIrq;
		logic lo;
		apb(1'b0, OFF_IRQ_STAT, '0);
		chk("irq status", rData, 32'h0000000f);
		apb(1'b1, OFF_IRQ_STAT, 32'h0000000f);
		apb(1'b0, OFF_IRQ_STAT, '0);
		chk("irq cleared", rData, 32'h0);
		chk("irq low", {31'h0, irq}, 32'h0);
		pulse(1'b0);
		repeat (2) @(posedge mclk);
		lo = irq;
		apb(1'b1, OFF_IRQ_MASK, 32'h0000000f);
		repeat (2) @(posedge mclk);
		chk("irq mask effect", {31'h0, lo ^ irq}, 32'h1);
		apb(1'b0, 12'h0f0, '0);
		chk("unmapped", {rErr, rData[30:0]}, 32'h80000000);
		$display("testIrq done");
	endtask
	// Main sequence.
	initial begin
		{rst, psel, penable, pwrite, busRst, idDone, isRoot, cpOk} = 8'h80;
		{pwdata, idNum, stall} = '0;
		paddr = '0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		testReset();
		testNode();
		testPhy();
		testIrq();
		giveVerdict();
	end
endmodule
